// [thsp_top.sv]
// file: touch host serial port, i2c or spi slave with data-ready line
`timescale 1ns/1ps
module thsp_top
	import thsp_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       ce_i,
	// mode and power
	input  wire logic       interface_select_strap_i,
	input  wire logic       sleep_i,
	// shared serial pins
	input  wire logic       serial_clk_i,
	output logic            serial_clk_o,
	output logic            serial_clk_oe_o,
	input  wire logic       shared_data_in_pin_i,
	output logic            shared_data_o,
	output logic            shared_data_oe_o,
	input  wire logic       slave_sel_n_i,
	// spi data out and ready lines
	output logic            serial_output_ready_pin_o,
	output logic            serial_output_ready_pin_oe_o,
	output logic            spi_data_ready_irq_o,
	// report source (touch engine)
	input  wire logic       rpt_valid_i,
	output logic            rpt_ready_o,
	input  wire logic [7:0] rpt_data_i,
	input  wire logic       rpt_first_i,
	// received command bytes
	output logic            cmd_valid_o,
	output logic [7:0]      cmd_data_o
);
	// ----------------------------------------------------------------
	// reset and input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	logic [3:0] s1_reg, s2_reg;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 4'hF;
			s2_reg <= 4'hF;
		end else if (ce_i) begin
			s1_reg <= {slave_sel_n_i, interface_select_strap_i,
			           shared_data_in_pin_i, serial_clk_i};
			s2_reg <= s1_reg;
		end
	end

	// glitch filter: level kept until stable for a few cycles
	logic [1:0] flt_reg, flt_next;
	logic [1:0] fcnt_reg [2];
	logic [1:0] fcnt_next [2];
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			flt_next[i]  = flt_reg[i];
			fcnt_next[i] = '0;
			if (s2_reg[i] != flt_reg[i]) begin
				fcnt_next[i] = fcnt_reg[i] + 1'b1;
				if (fcnt_reg[i] == 2'(THSP_GLITCH_CYC)) begin
					flt_next[i]  = s2_reg[i];
					fcnt_next[i] = '0;
				end
			end
		end
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			flt_reg     <= 2'b11;
			fcnt_reg[0] <= '0;
			fcnt_reg[1] <= '0;
		end else if (ce_i) begin
			flt_reg  <= flt_next;
			fcnt_reg <= fcnt_next;
		end
	end

	logic scl, sda, scl_d_reg, sda_d_reg, spi_mode, ss_n;
	assign scl = flt_reg[0];
	assign sda = flt_reg[1];
	assign spi_mode = s2_reg[2];
	assign ss_n     = s2_reg[3];
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else if (ce_i) begin
			scl_d_reg <= scl;
			sda_d_reg <= sda;
		end
	end
	logic scl_rise, scl_fall, i2c_start, i2c_stop;
	assign scl_rise  = scl & ~scl_d_reg;
	assign scl_fall  = ~scl & scl_d_reg;
	// start/stop seen only in i2c mode, data edge while clock high
	assign i2c_start = ~spi_mode & scl & scl_d_reg & sda_d_reg & ~sda;
	assign i2c_stop  = ~spi_mode & scl & scl_d_reg & ~sda_d_reg & sda;

	// ----------------------------------------------------------------
	// pending report buffer
	// ----------------------------------------------------------------
	logic       fifo_rvalid, fifo_pop, flush;
	logic [7:0] fifo_rdata;
	assign flush = sleep_i;
	thsp_fifo #(
		.W (THSP_FIFO_W),
		.D (THSP_FIFO_D)
	) u_fifo (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n),
		.ce_i     (ce_i),
		.flush_i  (flush),
		.wvalid_i (rpt_valid_i),
		.wready_o (rpt_ready_o),
		.wdata_i  (rpt_data_i),
		.rvalid_o (fifo_rvalid),
		.rready_i (fifo_pop),
		.rdata_o  (fifo_rdata)
	);

	// ----------------------------------------------------------------
	// serial engine, shared by both modes
	// ----------------------------------------------------------------
	thsp_state_e st_reg, st_next;
	logic [7:0]  sh_reg, sh_next, tx_reg, tx_next;
	logic [3:0]  bit_reg, bit_next;
	logic        drv_reg, drv_next, hold_reg, hold_next;
	logic        rdy_reg, rdy_next, cv_reg, cv_next;
	logic [7:0]  cd_reg, cd_next;
	logic [7:0]  load;

	assign load = fifo_rvalid ? fifo_rdata : THSP_SPI_FILL;

	always_comb begin
		st_next   = st_reg;
		sh_next   = sh_reg;
		tx_next   = tx_reg;
		bit_next  = bit_reg;
		drv_next  = drv_reg;
		hold_next = 1'b0;
		rdy_next  = rdy_reg;
		cv_next   = 1'b0;
		cd_next   = cd_reg;
		fifo_pop  = 1'b0;
		if (spi_mode) begin
			drv_next = 1'b0;
			st_next  = THSP_IDLE;
			if (ss_n) begin
				bit_next = '0;
				tx_next  = load;
			end else if (scl_rise) begin
				sh_next  = {sh_reg[6:0], sda};
				bit_next = bit_reg + 1'b1;
				if (bit_reg == THSP_BYTE_LAST) begin
					cv_next  = 1'b1;
					cd_next  = {sh_reg[6:0], sda};
					fifo_pop = fifo_rvalid;
					if (fifo_rvalid)
						rdy_next = 1'b0;
				end
			end else if (scl_fall) begin
				// shift out msb first on falling edge
				if (bit_reg == THSP_ACK_BIT) begin
					bit_next = '0;
					tx_next  = load;
				end else begin
					tx_next = {tx_reg[6:0], 1'b0};
				end
			end
		end else if (i2c_start) begin
			st_next  = THSP_ADDR;
			bit_next = '0;
			drv_next = 1'b0;
		end else if (i2c_stop) begin
			st_next  = THSP_IDLE;
			drv_next = 1'b0;
		end else begin
			unique case (st_reg)
			THSP_IDLE, THSP_SKIP: drv_next = 1'b0;
			THSP_ADDR, THSP_WR: begin
				// address and write data on rising edges
				if (scl_rise) begin
					sh_next  = {sh_reg[6:0], sda};
					bit_next = bit_reg + 1'b1;
				end
				if (scl_fall && bit_reg == THSP_ACK_BIT) begin
					bit_next = '0;
					if (st_reg == THSP_ADDR) begin
						if (sh_reg[7:1] == THSP_I2C_ADDR) begin
							drv_next = 1'b1;
							st_next  = THSP_AACK;
						end else begin
							st_next = THSP_SKIP;
						end
					end else begin
						// ack every data byte, pass it on
						drv_next = 1'b1;
						cv_next  = 1'b1;
						cd_next  = sh_reg;
						st_next  = THSP_WACK;
					end
				end
			end
			THSP_AACK, THSP_WACK, THSP_RACK: begin
				if (scl_fall) begin
					if (st_reg == THSP_RACK && sda) begin
						drv_next = 1'b0;
						st_next  = THSP_SKIP;
					end else if (st_reg == THSP_WACK ||
					             (st_reg == THSP_AACK && !sh_reg[0])) begin
						drv_next = 1'b0;
						st_next  = THSP_WR;
					end else if (!fifo_rvalid && st_reg != THSP_RACK) begin
						// stretch clock until a byte exists
						hold_next = 1'b1;
						st_next   = st_reg;
					end else begin
						// first bit driven after falling edge
						tx_next  = load;
						drv_next = ~load[7];
						fifo_pop = fifo_rvalid;
						if (fifo_rvalid)
							rdy_next = 1'b0;
						st_next  = THSP_RD;
					end
				end else if (st_reg == THSP_AACK && hold_reg &&
				             !fifo_rvalid) begin
					hold_next = 1'b1;
				end else if (st_reg == THSP_AACK && hold_reg) begin
					tx_next  = load;
					drv_next = ~load[7];
					fifo_pop = 1'b1;
					rdy_next = 1'b0;
					st_next  = THSP_RD;
				end
				if (scl_rise && st_reg == THSP_RACK)
					drv_next = 1'b0;
			end
			THSP_RD: begin
				// shift out after each falling edge
				if (scl_fall) begin
					bit_next = bit_reg + 1'b1;
					if (bit_reg == THSP_BYTE_LAST) begin
						bit_next = '0;
						drv_next = 1'b0;
						st_next  = THSP_RACK;
					end else begin
						tx_next  = {tx_reg[6:0], 1'b0};
						drv_next = ~tx_reg[6];
					end
				end
			end
			default: st_next = THSP_IDLE;
			endcase
		end
		// raise ready as a packet arrives; a new packet
		// outranks a pop of the old one in the same cycle
		if (rpt_valid_i & rpt_ready_o & rpt_first_i)
			rdy_next = 1'b1;
		if (flush)
			rdy_next = 1'b0;
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg   <= THSP_IDLE;
			sh_reg   <= '0;
			tx_reg   <= THSP_SPI_FILL;
			bit_reg  <= '0;
			drv_reg  <= 1'b0;
			hold_reg <= 1'b0;
			rdy_reg  <= 1'b0;
			cv_reg   <= 1'b0;
			cd_reg   <= '0;
		end else if (ce_i) begin
			st_reg   <= st_next;
			sh_reg   <= sh_next;
			tx_reg   <= tx_next;
			bit_reg  <= bit_next;
			drv_reg  <= drv_next;
			hold_reg <= hold_next;
			rdy_reg  <= rdy_next;
			cv_reg   <= cv_next;
			cd_reg   <= cd_next;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// open-drain lines only ever pull low
	assign serial_clk_o     = 1'b0;
	assign serial_clk_oe_o  = hold_reg & ~spi_mode;
	assign shared_data_o    = 1'b0;
	assign shared_data_oe_o = drv_reg & ~spi_mode;
	// i2c: ready flag; spi: data, tri-stated if deselected
	assign serial_output_ready_pin_o    = spi_mode ? tx_reg[7] : rdy_reg;
	assign serial_output_ready_pin_oe_o = ~(spi_mode & ss_n);
	assign spi_data_ready_irq_o = spi_mode & rdy_reg;
	assign cmd_valid_o = cv_reg;
	assign cmd_data_o  = cd_reg;
endmodule : thsp_top

// [thsp_pkg.sv]
// package: constants for the touch host serial port
package thsp_pkg;
	localparam logic [6:0] THSP_I2C_ADDR   = 7'h4D;
	localparam logic [7:0] THSP_SPI_FILL   = 8'h4D;
	localparam int         THSP_FIFO_W     = 8;
	localparam int         THSP_FIFO_D     = 32;
	localparam int         THSP_GLITCH_CYC = 2;
	localparam logic [3:0] THSP_ACK_BIT    = 4'h8;
	localparam logic [3:0] THSP_BYTE_LAST  = 4'h7;

	typedef enum logic [2:0] {
		THSP_IDLE, THSP_ADDR, THSP_AACK, THSP_WR, THSP_WACK, THSP_RD,
		THSP_RACK, THSP_SKIP
	} thsp_state_e;
endpackage : thsp_pkg

// [thsp_fifo.sv]
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module thsp_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic         flush_i,
	// write side
	input  wire logic         wvalid_i,
	output logic              wready_o,
	input  wire logic [W-1:0] wdata_i,
	// read side
	output logic              rvalid_o,
	input  wire logic         rready_i,
	output logic [W-1:0]      rdata_o
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_reg [D];
	logic [W-1:0] mem_next [D];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          wr, rd;

	assign wready_o = (cnt_reg != (AW+1)'(D));
	assign rvalid_o = (cnt_reg != '0);
	assign rdata_o  = mem_reg[rp_reg];
	assign wr       = wvalid_i & wready_o;
	assign rd       = rready_i & rvalid_o;

	// next pointers and storage
	always_comb begin
		mem_next = mem_reg;
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		cnt_next = cnt_reg;
		if (flush_i) begin
			wp_next  = '0;
			rp_next  = '0;
			cnt_next = '0;
		end else begin
			if (wr) begin
				mem_next[wp_reg] = wdata_i;
				wp_next = (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
			end
			if (rd)
				rp_next = (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
			if (wr & ~rd)
				cnt_next = cnt_reg + 1'b1;
			else if (rd & ~wr)
				cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < D; i++)
				mem_reg[i] <= '0;
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else if (ce_i) begin
			mem_reg <= mem_next;
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule : thsp_fifo

// [thsp_host.sv]
// host master model for the i2c and spi sides of the port
`timescale 1ns/1ps
// ----------------------------------------
// host master
// ----------------------------------------
module thsp_host (
	// wire levels seen by the host
	input  wire logic scl_i,
	input  wire logic dat_i,
	input  wire logic miso_i,
	// host drives
	output logic      scl_low_o,
	output logic      dat_low_o,
	output logic      sck_o,
	output logic      mosi_o,
	output logic      ss_n_o,
	output logic      stuck_o
);
	// pause before a stop, for a device that does not stretch on writes
	realtime stop_gap = 0.0;
	// idle: both wires released, spi deselected
	initial begin
		{scl_low_o, dat_low_o, sck_o, mosi_o, stuck_o} = 5'h00;
		ss_n_o = 1'b1;
	end
	task start();
		#62.5 dat_low_o = 1'b1;
		#62.5 scl_low_o = 1'b1;
	endtask : start
	task stop();
		// wait after the last command byte before the stop
		#(stop_gap);
		#31 dat_low_o = 1'b1;
		#31 scl_low_o = 1'b0;
		#62.5 dat_low_o = 1'b0;
		#62.5;
	endtask : stop
	// nine clocks; tx[0] is the ack slot, a 1 leaves the wire free
	task xfer(input logic [8:0] tx, output logic [8:0] rx);
		int n;
		for (int i = 8; i >= 0; i--) begin
			#31 dat_low_o = !tx[i];
			#31 scl_low_o = 1'b0;
			// wait out a stretch, bounded so a hang ends the run
			for (n = 0; n < 4000 && !scl_i; n++) #5;
			if (!scl_i) stuck_o = 1'b1;
			#31 rx[i] = dat_i;
			#31 scl_low_o = 1'b1;
		end
	endtask : xfer
	// clock idles low; sample on rise, data moves on fall
	task spi(input logic [7:0] tx, output logic [7:0] rx);
		ss_n_o = 1'b0;
		#250;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#62.5 sck_o = 1'b1;
			rx[i] = miso_i;
			#62.5 sck_o = 1'b0;
		end
		// inter-byte gap, shortened to keep the run small
		#500 ss_n_o = 1'b1;
		#125;
	endtask : spi
endmodule : thsp_host

// [thsp_top_chk.sv]
// concurrent checks on the touch host serial port pins
`timescale 1ns/1ps
module thsp_top_chk (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// watched pins
	input wire logic interface_select_strap_i,
	input wire logic sleep_i,
	input wire logic serial_clk_i,
	input wire logic serial_clk_o,
	input wire logic shared_data_oe_o,
	input wire logic slave_sel_n_i,
	input wire logic serial_output_ready_pin_o,
	input wire logic serial_output_ready_pin_oe_o,
	input wire logic spi_data_ready_irq_o,
	input wire logic rpt_valid_i,
	input wire logic rpt_ready_o,
	input wire logic rpt_first_i
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_clk_pull_low: assert property (serial_clk_o == 1'b0)
		else $error("clock pin driven high");
	// data wire moves only while clock low
	a_dat_move_low: assert property (!$stable(shared_data_oe_o)
		|-> !serial_clk_i)
		else $error("data wire moved with clock high");
	// spi data out moves only while clock low
	a_out_move_low: assert property (interface_select_strap_i
		&& !slave_sel_n_i && !$stable(serial_output_ready_pin_o)
		|-> !serial_clk_i)
		else $error("spi data moved with clock high");
	a_out_hiz: assert property ((interface_select_strap_i
		&& slave_sel_n_i)[*6] |-> !serial_output_ready_pin_oe_o)
		else $error("data out driven while deselected");
	a_irq_i2c_zero: assert property ((!interface_select_strap_i)[*6]
		|-> !spi_data_ready_irq_o && serial_output_ready_pin_oe_o)
		else $error("spi ready active in i2c mode");
	a_rdy_raise: assert property ((!interface_select_strap_i
		&& !sleep_i)[*6] ##0 (rpt_valid_i && rpt_ready_o && rpt_first_i)
		|-> ##[1:8] serial_output_ready_pin_o)
		else $error("ready pin not raised");
	a_irq_raise: assert property ((interface_select_strap_i
		&& !sleep_i)[*6] ##0 (rpt_valid_i && rpt_ready_o && rpt_first_i)
		|-> ##[1:8] spi_data_ready_irq_o)
		else $error("spi ready not raised");
	a_sleep_clear: assert property (sleep_i[*6] |-> !spi_data_ready_irq_o
		&& (interface_select_strap_i || !serial_output_ready_pin_o))
		else $error("ready survives sleep");
endmodule : thsp_top_chk

bind thsp_top thsp_top_chk chk_i (.clock_i, .rstn_i,
	.interface_select_strap_i, .sleep_i, .serial_clk_i, .serial_clk_o,
	.shared_data_oe_o, .slave_sel_n_i, .serial_output_ready_pin_o,
	.serial_output_ready_pin_oe_o, .spi_data_ready_irq_o, .rpt_valid_i,
	.rpt_ready_o, .rpt_first_i);

// [tb_touch_host_serial_port.sv]
// self-checking bench for the touch host serial port
`timescale 1ns/1ps
module tb_touch_host_serial_port;
	// ----------------------------------------
	// bench signals
	// ----------------------------------------
	logic       clk, rstn, strap, sleep, vld, first, ok, hold;
	logic [7:0] data, cmd;
	logic       scl_oe, dat_oe, dout, dout_oe, irq, rdy, cmd_vld;
	logic       scl_low, dat_low, sck, mosi, ss_n, stuck;
	logic [7:0] cmdq [$];
	int         err_total, checks;
	// both open-drain wires have pull-ups
	wire logic  scl_w = !(scl_low || scl_oe);
	wire logic  dat_w = !(dat_low || dat_oe);
	// released data out shows the inverse of its last level
	wire logic  miso  = dout_oe ? dout : hold;

	thsp_top dut (.clock_i(clk), .rstn_i(rstn), .ce_i(1'b1),
		.interface_select_strap_i(strap), .sleep_i(sleep),
		.serial_clk_i(strap ? sck : scl_w), .serial_clk_o(),
		.serial_clk_oe_o(scl_oe), .shared_data_in_pin_i(strap ? mosi : dat_w),
		.shared_data_o(), .shared_data_oe_o(dat_oe), .slave_sel_n_i(ss_n),
		.serial_output_ready_pin_o(dout),
		.serial_output_ready_pin_oe_o(dout_oe), .spi_data_ready_irq_o(irq),
		.rpt_valid_i(vld), .rpt_ready_o(rdy), .rpt_data_i(data),
		.rpt_first_i(first), .cmd_valid_o(cmd_vld), .cmd_data_o(cmd));
	thsp_host host (.scl_i(scl_w), .dat_i(dat_w), .miso_i(miso),
		.scl_low_o(scl_low), .dat_low_o(dat_low), .sck_o(sck),
		.mosi_o(mosi), .ss_n_o(ss_n), .stuck_o(stuck));

	// 200 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	// collect command bytes, remember the inverse of the last driven level
	always @(posedge clk) begin
		if (cmd_vld === 1'b1) cmdq.push_back(cmd);
		if (dout_oe) hold <= !dout;
	end
	// a stretch that never ends closes the run
	always @(posedge stuck) begin
		err_total++;
		give_verdict();
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task give_verdict();
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : wt
	// offer one byte; ok tells whether the buffer took it
	task push(input logic [7:0] d, input logic f);
		vld = 1'b1;
		data = d;
		first = f;
		@(posedge clk);
		ok = rdy;
		#1;
	endtask : push
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_i2c_write();
		logic [8:0] rx;
		logic [7:0] seq [5] = '{8'h9A, 8'h00, 8'h55, 8'h01, 8'h12};
		cmdq.delete();
		host.start();
		foreach (seq[i]) begin
			host.xfer({seq[i], 1'b1}, rx);
			chk(rx[0], 1'b0);
		end
		host.stop_gap = 50000.0;
		host.stop();
		host.stop_gap = 0.0;
		chk(9'(cmdq.size()), 9'd4);
		for (int i = 1; i < 5; i++) chk(cmdq[i-1], seq[i]);
	endtask : t_i2c_write
	task t_i2c_bad();
		logic [8:0] rx;
		logic [7:0] bad [4] = '{8'h9C, 8'h98, 8'h1A, 8'hDB};
		cmdq.delete();
		foreach (bad[i]) begin
			host.start();
			host.xfer({bad[i], 1'b1}, rx);
			chk(rx[0], 1'b1);
			host.xfer({8'h12, 1'b1}, rx);
			chk(rx[0], 1'b1);
			host.stop();
		end
		chk(9'(cmdq.size()), 9'd0);
	endtask : t_i2c_bad
	task t_i2c_read();
		logic [8:0] rx;
		wt(2);
		for (int i = 0; i < 3; i++) push(8'(8'hA0 + i), i == 0);
		vld = 1'b0;
		wt(20);
		chk(dout, 1'b1);
		host.start();
		host.xfer({8'h9B, 1'b1}, rx);
		chk(rx[0], 1'b0);
		for (int i = 0; i < 3; i++) begin
			host.xfer({8'hFF, i == 2}, rx);
			chk(rx[8:1], 9'(8'hA0 + i));
			chk(dout, 1'b0);
		end
		host.stop();
		// empty buffer: clock held low until a byte arrives
		host.start();
		host.xfer({8'h9B, 1'b1}, rx);
		wt(40);
		chk(scl_oe, 1'b1);
		fork
			host.xfer({8'hFF, 1'b1}, rx);
			begin
				wt(30);
				push(8'h5A, 1'b1);
				vld = 1'b0;
			end
		join
		chk(rx[8:1], 9'h05A);
		chk(dout, 1'b0);
		host.stop();
	endtask : t_i2c_read
	task t_spi();
		logic [7:0] rx;
		int n;
		wt(2);
		push(8'h81, 1'b1);
		vld = 1'b0;
		wt(20);
		sleep = 1'b1;
		wt(20);
		chk(dout, 1'b0);
		sleep = 1'b0;
		strap = 1'b1;
		wt(20);
		chk(dout_oe, 1'b0);
		cmdq.delete();
		host.spi(8'h00, rx);
		chk(rx, 8'h4D);
		wt(2);
		// fill until the buffer refuses
		n = 0;
		for (int i = 0; i < 34; i++) begin
			push(8'(8'h40 + i), i == 0);
			n += int'(ok);
		end
		vld = 1'b0;
		chk(9'(n), 9'd32);
		wt(10);
		chk(irq, 1'b1);
		for (int i = 0; i < 32; i++) begin
			host.spi(8'(i), rx);
			chk(rx, 8'(8'h40 + i));
			if (i == 0) chk(irq, 1'b0);
		end
		host.spi(8'hC3, rx);
		chk(rx, 8'h4D);
		chk(9'(cmdq.size()), 9'd34);
		chk(cmdq[33], 8'hC3);
	endtask : t_spi
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, strap, sleep, vld, first, data} = '0;
		repeat (20) @(posedge clk);
		#1 rstn = 1'b1;
		wt(12);
		chk(dout, 1'b0);
		t_i2c_write();
		t_i2c_bad();
		t_i2c_read();
		t_spi();
		give_verdict();
	end
endmodule : tb_touch_host_serial_port
